// [rtl/acc_conv_ctrl.sv]
// Converter conversion control, result registers and trigger logic.
//
// Behaviour
// - Single mode: each write of one to start and enable bits while not busy begins a conversion.
// - Free running: first start write launches, then conversions run back to back.
// - First conversion after enable, or started with enable, takes 25 cycles not 13.
// - Start bit reads one while busy, clears at completion; writing zero ignored.
// - Auto trigger enabled: rising edge of selected trigger starts a conversion.
// - Complete flag sets when conversion finishes and results are updated.
// - Interrupt request while flag, interrupt enable and global enable are set.
// - Flag clears on vector taken or writing one; writing zero leaves it.
// - Prescaler codes 0,1 divide by 2; codes 2..7 divide by 4..128.
// - Right adjust: high byte holds bits 9:8, low byte bits 7:0.
// - Left adjust: high byte holds bits 9:2, low byte bits 1:0 at 7:6.
// - Reading low byte blocks result updates until high byte is read.
// - Trigger source has no effect while auto trigger is disabled.
// - Switching to a set trigger source from a clear one starts a conversion.
// - Selecting free running never by itself creates a trigger event.
// - Trigger codes: free, comparator, ext irq0, t0 cmpA, t0 ovf, t1 cmpB, t1 ovf, t1 capt.
// - Disable bit set turns pin input buffer off; port bit reads zero.
// - Inputs 7 and 6 have no digital buffer and no disable bit.
// - Clearing converter enable turns off and aborts any conversion.
// - Reference and channel changes take effect only after conversion completes.
`timescale 1ns/1ps
`default_nettype none

module acc_conv_ctrl
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [2:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  // Core interrupt handshake
  input  wire logic        global_ie_in,
  input  wire logic        irq_ack_in,
  output logic             irq_out,
  // Trigger sources, index 1..7
  input  wire logic [7:1]  trig_src_in,
  // Analog core
  input  wire logic [9:0]  sample_data_in,
  output logic             conv_clk_out,
  output logic             conv_busy_out,
  output logic             conv_on_out,
  output logic      [3:0]  channel_out,
  output logic      [1:0]  reference_out,
  // Digital pins
  input  wire logic [7:0]  pin_raw_in,
  output logic      [7:0]  pin_value_out,
  output logic      [5:0]  pin_buf_en_out
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic       enable_reg, auto_reg, flag_reg, ie_reg;
  logic [2:0] psc_reg;
  logic [2:0] trig_sel_reg;
  logic [7:0] sel_reg;
  logic [3:0] channel_reg;
  logic [1:0] reference_reg;
  logic [5:0] dis_reg;
  logic [9:0] result_reg;
  logic       lock_reg;
  logic       first_reg;
  logic       trig_prev_reg;
  acc_state_t state_reg;
  logic [6:0] div_reg;
  logic [4:0] cyc_reg;
  logic [4:0] len_reg;
  logic [7:0] rdata_reg;
  logic [7:0] pin_reg;
  acc_bus_t   bus;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire wr_a    = bus.wr && (bus.addr == ACC_OFS_CTRL_A);
  wire wr_b    = bus.wr && (bus.addr == ACC_OFS_CTRL_B);
  wire wr_sel  = bus.wr && (bus.addr == ACC_OFS_IN_SEL);
  wire wr_dis  = bus.wr && (bus.addr == ACC_OFS_DIS);
  wire rd_lo   = bus.rd && (bus.addr == ACC_OFS_RES_LO);
  wire rd_hi   = bus.rd && (bus.addr == ACC_OFS_RES_HI);
  wire en_next = wr_a ? bus.wdata[ACC_BIT_EN] : enable_reg;
  wire busy    = (state_reg == ACC_BUSY);
  wire left    = sel_reg[ACC_BIT_LEFT];

  // Prescaler: tick on the last system clock of each converter clock period.
  wire [2:0] psc_eff  = (psc_reg == 3'h0) ? 3'h1 : psc_reg;
  wire [6:0] div_top  = 7'((8'h01 << psc_eff) - 8'h01);
  wire       conv_tick = (div_reg == div_top);

  // Trigger: selected level; free running restarts on done but never fires on selection.
  wire [7:0] src_vec  = {trig_src_in, 1'b0};
  wire       trig_lvl = src_vec[trig_sel_reg];
  wire       trig_edge = trig_lvl && !trig_prev_reg;
  wire       done     = busy && conv_tick && (cyc_reg == len_reg - 5'd1);
  wire       free_run = (trig_sel_reg == ACC_TRIG_FREE);
  wire       auto_go  = enable_reg && auto_reg &&
                        (free_run ? done : trig_edge);
  wire       sw_go    = wr_a && bus.wdata[ACC_BIT_START] && en_next;
  wire       start    = en_next && (sw_go || auto_go) && (!busy || done);
  wire       flag_clr = irq_ack_in || (wr_a && bus.wdata[ACC_BIT_FLAG]);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      enable_reg   <= 1'b0;
      auto_reg     <= 1'b0;
      ie_reg       <= 1'b0;
      psc_reg      <= 3'h0;
      trig_sel_reg <= 3'h0;
      sel_reg      <= ACC_RST_BYTE;
      dis_reg      <= 6'h00;
    end else begin
      if (wr_a) begin
        enable_reg <= bus.wdata[ACC_BIT_EN];
        auto_reg   <= bus.wdata[ACC_BIT_AUTO];
        ie_reg     <= bus.wdata[ACC_BIT_IE];
        psc_reg    <= bus.wdata[2:0];
      end
      if (wr_b) begin
        trig_sel_reg <= bus.wdata[2:0];
      end
      if (wr_sel) begin
        sel_reg <= bus.wdata & ACC_MASK_SEL;
      end
      if (wr_dis) begin
        dis_reg <= bus.wdata[5:0];
      end
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg     <= ACC_IDLE;
      div_reg       <= 7'h00;
      cyc_reg       <= 5'h00;
      len_reg       <= ACC_CONV_NORMAL;
      first_reg     <= 1'b0;
      trig_prev_reg <= 1'b0;
      channel_reg   <= 4'h0;
      reference_reg <= 2'h0;
    end else begin
      trig_prev_reg <= trig_lvl;
      div_reg <= (conv_tick || !en_next) ? 7'h00 : div_reg + 7'h01;
      if (!enable_reg && en_next) begin
        first_reg <= 1'b1;
      end
      if (!en_next) begin
        state_reg <= ACC_IDLE;
      end else if (start) begin
        state_reg <= ACC_BUSY;
        cyc_reg   <= 5'h00;
        div_reg   <= 7'h00;
        len_reg   <= (first_reg || !enable_reg) ? ACC_CONV_FIRST : ACC_CONV_NORMAL;
        first_reg <= 1'b0;
      end else if (done) begin
        state_reg <= ACC_IDLE;
      end else if (busy && conv_tick) begin
        cyc_reg <= cyc_reg + 5'd1;
      end
      // Selection reaches the analog core only between conversions.
      if (!busy || done) begin
        channel_reg   <= sel_reg[3:0];
        reference_reg <= sel_reg[7:6];
      end
    end
  end

  // ****************************************************************
  // Result, lock and flag
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result_reg <= 10'h000;
      lock_reg   <= 1'b0;
      flag_reg   <= 1'b0;
    end else begin
      if (rd_lo) begin
        lock_reg <= 1'b1;
      end else if (rd_hi) begin
        lock_reg <= 1'b0;
      end
      // A locked result is lost rather than stalling the converter.
      if (done && !lock_reg) begin
        result_reg <= sample_data_in;
        flag_reg   <= 1'b1;
      end else if (flag_clr) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read data and pins
  // ****************************************************************
  wire [7:0] res_hi = left ? result_reg[9:2] : {6'h00, result_reg[9:8]};
  wire [7:0] res_lo = left ? {result_reg[1:0], 6'h00} : result_reg[7:0];
  wire [7:0] ctrl_a = {enable_reg, busy, auto_reg, flag_reg, ie_reg, psc_reg};
  wire [7:0] rd_mux =
    (bus.addr == ACC_OFS_CTRL_A) ? ctrl_a :
    (bus.addr == ACC_OFS_CTRL_B) ? ({5'h00, trig_sel_reg} & ACC_MASK_B) :
    (bus.addr == ACC_OFS_IN_SEL) ? sel_reg :
    (bus.addr == ACC_OFS_RES_LO) ? res_lo :
    (bus.addr == ACC_OFS_RES_HI) ? res_hi :
    (bus.addr == ACC_OFS_DIS)    ? ({2'h0, dis_reg} & ACC_MASK_DIS) : 8'h00;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
      pin_reg   <= 8'h00;
    end else begin
      rdata_reg <= bus.rd ? rd_mux : 8'h00;
      pin_reg   <= {2'b00, pin_raw_in[5:0] & ~dis_reg};
    end
  end

  assign rdata_out      = rdata_reg;
  assign irq_out        = flag_reg && ie_reg && global_ie_in;
  assign conv_clk_out   = enable_reg && (div_reg <= {1'b0, div_top[6:1]});
  assign conv_busy_out  = busy;
  assign conv_on_out    = enable_reg;
  assign channel_out    = channel_reg;
  assign reference_out  = reference_reg;
  assign pin_value_out  = pin_reg;
  assign pin_buf_en_out = ~dis_reg;

endmodule

`default_nettype wire

// [rtl/acc_pkg.sv]
// Package for the converter control block: register map, fields, timing counts.
package acc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [2:0] ACC_OFS_CTRL_A  = 3'h0;
  localparam logic [2:0] ACC_OFS_CTRL_B  = 3'h1;
  localparam logic [2:0] ACC_OFS_IN_SEL  = 3'h2;
  localparam logic [2:0] ACC_OFS_RES_LO  = 3'h3;
  localparam logic [2:0] ACC_OFS_RES_HI  = 3'h4;
  localparam logic [2:0] ACC_OFS_DIS     = 3'h5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ACC_BIT_EN    = 7;
  localparam int ACC_BIT_START = 6;
  localparam int ACC_BIT_AUTO  = 5;
  localparam int ACC_BIT_FLAG  = 4;
  localparam int ACC_BIT_IE    = 3;
  localparam int ACC_BIT_LEFT  = 5;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [7:0] ACC_RST_BYTE  = 8'h00;
  localparam logic [7:0] ACC_MASK_B    = 8'h47;
  localparam logic [7:0] ACC_MASK_SEL  = 8'hEF;
  localparam logic [7:0] ACC_MASK_DIS  = 8'h3F;

  // ****************************************************************
  // Timing counts in converter clock cycles
  // ****************************************************************
  localparam logic [4:0] ACC_CONV_NORMAL = 5'd13;
  localparam logic [4:0] ACC_CONV_FIRST  = 5'd25;

  // ****************************************************************
  // Trigger sources
  // ****************************************************************
  localparam logic [2:0] ACC_TRIG_FREE = 3'h0;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_BUSY
  } acc_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acc_bus_t;

endpackage

// [testbench/acc_conv_ctrl_properties.sv]
// Concurrent port checks for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl_chk
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // Register port and core handshake
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       global_ie_in,
  input wire logic       irq_ack_in,
  // Observed outputs
  input wire logic       irq_out,
  input wire logic       conv_busy_out,
  input wire logic       conv_on_out,
  input wire logic [7:0] pin_value_out,
  input wire logic [5:0] pin_buf_en_out
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence wr_a;
    wr_in && (addr_in == ACC_OFS_CTRL_A);
  endsequence
  sequence idle_wr;
    wr_a ##0 !conv_busy_out;
  endsequence
  start_begins_a: assert property (idle_wr ##0 (wdata_in[7] && wdata_in[6]) |=> conv_busy_out)
    else $error("start write did not begin a conversion");
  zero_start_a: assert property (idle_wr ##0 !(wdata_in[6] || wdata_in[5]) |=> !conv_busy_out)
    else $error("zero start write began a conversion");
  disable_abort_a: assert property (wr_a ##0 !wdata_in[7] |=> !conv_on_out && !conv_busy_out)
    else $error("clearing enable left converter running");
  off_idle_a: assert property (!conv_on_out |-> !conv_busy_out)
    else $error("busy while converter is off");
  irq_gate_a: assert property (irq_out |-> global_ie_in)
    else $error("interrupt without global enable");
  ack_clear_a: assert property (irq_ack_in && !conv_busy_out |=> !irq_out)
    else $error("vector taken did not clear flag");
  write_clear_a: assert property (idle_wr ##0 wdata_in[ACC_BIT_FLAG] |=> !irq_out)
    else $error("writing one did not clear flag");
  no_buffer_a: assert property (pin_value_out[7:6] == 2'b00)
    else $error("unbuffered inputs read nonzero");
  pin_off_a: assert property ((pin_value_out & {2'b00, ~$past(pin_buf_en_out)}) == 8'h00)
    else $error("disabled pin reads nonzero");
endmodule
bind acc_conv_ctrl acc_conv_ctrl_chk acc_conv_ctrl_chk_i (.clk_in, .rst_in, .addr_in,
  .wdata_in, .wr_in, .global_ie_in, .irq_ack_in, .irq_out, .conv_busy_out, .conv_on_out,
  .pin_value_out, .pin_buf_en_out);
`default_nettype wire

// [testbench/acc_conv_ctrl_tb.sv]
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl_tb
  import acc_pkg::*;
;
  logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, global_ie_in = 0, irq_ack_in = 0;
  logic [2:0] addr_in = 0;
  logic [7:0] wdata_in = 0, pin_raw_in = 0, rdata_out, pin_value_out;
  logic [7:1] trig_src_in = 0;
  logic [9:0] sample_data_in = 10'h2A5;
  logic irq_out, conv_busy_out, conv_on_out;
  logic [3:0] channel_out;
  logic [1:0] reference_out;
  logic [5:0] pin_buf_en_out;
  int fails = 0, comparisons = 0;
  acc_conv_ctrl acc_conv_ctrl_i (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .global_ie_in, .irq_ack_in, .irq_out, .trig_src_in, .sample_data_in,
    .conv_clk_out(), .conv_busy_out, .conv_on_out, .channel_out, .reference_out,
    .pin_raw_in, .pin_value_out, .pin_buf_en_out);
  always #2 clk_in = ~clk_in;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask
  // Counts busy cycles; a conversion that never starts runs into the bound and mismatches.
  task automatic conv(input logic [7:0] e);
    logic [7:0] n;
    n = 0;
    #1;
    repeat (300) begin
      if (conv_busy_out === 1'b1) n++;
      else if (n > 0) break;
      @(posedge clk_in); #1;
    end
    chk(n, e);
  endtask
  task automatic fin(input string s);
    $display("%0t test %s done", $time, s);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #40000 fails++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    fin("reset");
    wr(ACC_OFS_CTRL_A, 8'hC0); conv(8'd50);
    rd(ACC_OFS_CTRL_A, 8'h90);
    rd(ACC_OFS_RES_LO, 8'hA5); rd(ACC_OFS_RES_HI, 8'h02);
    global_ie_in <= 1'b1;
    wr(ACC_OFS_CTRL_A, 8'hC9); conv(8'd26);
    chk({7'd0, irq_out}, 8'h01);
    @(posedge clk_in) irq_ack_in <= 1'b1;
    @(posedge clk_in) irq_ack_in <= 1'b0;
    #1 chk({7'd0, irq_out}, 8'h00);
    wr(ACC_OFS_IN_SEL, 8'h20);
    rd(ACC_OFS_RES_LO, 8'h40); rd(ACC_OFS_RES_HI, 8'hA9);
    wr(ACC_OFS_CTRL_A, 8'hCA); conv(8'd52);
    wr(ACC_OFS_CTRL_A, 8'h90); rd(ACC_OFS_CTRL_A, 8'h80);
    fin("single");
    sample_data_in <= 10'h155;
    rd(ACC_OFS_RES_LO, 8'h40);
    wr(ACC_OFS_CTRL_A, 8'hC1); conv(8'd26);
    rd(ACC_OFS_CTRL_A, 8'h81); rd(ACC_OFS_RES_HI, 8'hA9);
    wr(ACC_OFS_CTRL_A, 8'hC1); conv(8'd26);
    rd(ACC_OFS_RES_HI, 8'h55);
    fin("lock");
    wr(ACC_OFS_CTRL_A, 8'h81);
    wr(ACC_OFS_CTRL_B, 8'h02);
    trig_src_in <= 7'h02;
    repeat (4) @(posedge clk_in);
    #1 chk({7'd0, conv_busy_out}, 8'h00);
    trig_src_in <= 7'h00;
    wr(ACC_OFS_CTRL_A, 8'hA1);
    for (int c = 1; c < 8; c++) begin
      wr(ACC_OFS_CTRL_B, c[7:0]);
      @(posedge clk_in) trig_src_in[c] <= 1'b1;
      conv(8'd26);
      trig_src_in <= 7'h00;
    end
    wr(ACC_OFS_CTRL_B, 8'h02);
    trig_src_in <= 7'h04;
    wr(ACC_OFS_CTRL_B, 8'h03); conv(8'd26);
    wr(ACC_OFS_CTRL_B, 8'h00);
    repeat (4) @(posedge clk_in);
    #1 chk({7'd0, conv_busy_out}, 8'h00);
    fin("trigger");
    wr(ACC_OFS_CTRL_A, 8'hE1);
    repeat (40) @(posedge clk_in);
    rd(ACC_OFS_CTRL_A, 8'hF1);
    wr(ACC_OFS_CTRL_A, 8'h00); rd(ACC_OFS_CTRL_A, 8'h10);
    fin("free running");
    // A selection written mid-conversion must wait for completion.
    wr(ACC_OFS_CTRL_A, 8'hC1);
    wr(ACC_OFS_IN_SEL, 8'h43);
    #1 chk({2'b00, reference_out, channel_out}, 8'h00);
    conv(8'd48);
    chk({2'b00, reference_out, channel_out}, 8'h13);
    chk({7'd0, conv_on_out}, 8'h01);
    fin("selection");
    pin_raw_in <= 8'hFF;
    wr(ACC_OFS_DIS, 8'h05);
    repeat (2) @(posedge clk_in);
    #1 chk(pin_value_out, 8'h3A);
    chk({2'b00, pin_buf_en_out}, 8'h3A);
    rd(ACC_OFS_DIS, 8'h05);
    fin("pins");
    report_and_stop();
  end
endmodule
`default_nettype wire
